// [shared/conv_pkg.sv]
// Constants, register map and state layout of the converter control block
//
// How it works
// - Analog-configured port pins read back low
// - Conversion starts regardless of direction or channel
// - Halve and divide bits pick period or RC
// - Clearing the go flag aborts the conversion
// - Abort leaves the result pair untouched
// - Go or enable abort waits two periods, then acquisition resumes
// - First segment lasts one instruction cycle to one period
// - Result loaded into 16 bits, zero filled
// - Format bit picks right or left justification
// - Result bytes are plain storage for software
// - RC clock waits one instruction cycle, runs in Sleep
// - Sleep completion clears go, loads, may wake
// - Sleep without RC clock aborts, enable stays set
// - Reset restores registers and makes pins analog
// - Result pair survives resets, unknown at power-on
// - Trigger in mode 1011 starts and clears timer
// - Disabled converter ignores trigger, timer still cleared
// - Output-configured pin converts its driven level
// - Digital-input pin still converts its analog level
// - Completion loads result, clears go, sets flag
// - A conversion takes nine bit periods
// - Two bit periods of hold after completion
package conv_pkg;
	// ==========================================================
	// Register indices, byte address is four times the index
	localparam logic [7:0] IDX_PORT  = 8'h05;
	localparam logic [7:0] IDX_INTC  = 8'h0b;
	localparam logic [7:0] IDX_PIR   = 8'h0c;
	localparam logic [7:0] IDX_RESH  = 8'h1e;
	localparam logic [7:0] IDX_CTL0  = 8'h1f;
	localparam logic [7:0] IDX_DIR   = 8'h85;
	localparam logic [7:0] IDX_PIE   = 8'h8c;
	localparam logic [7:0] IDX_RESL  = 8'h9e;
	localparam logic [7:0] IDX_CTL1  = 8'h9f;
	// ==========================================================
	// Reset values and writable masks
	localparam logic [7:0] RST_DIR   = 8'hff;
	localparam logic [7:0] RST_ZERO  = 8'h00;
	localparam logic [7:0] MASK_CTL0 = 8'hfd;
	localparam logic [7:0] MASK_CTL1 = 8'hcf;
	localparam logic [7:0] MASK_PIRE = 8'h4f;
	// ==========================================================
	// Field positions
	localparam int unsigned CTL0_DIV  = 6;
	localparam int unsigned CTL0_CHS  = 3;
	localparam int unsigned CTL0_GO   = 2;
	localparam int unsigned CTL0_ON   = 0;
	localparam int unsigned CTL1_FMT  = 7;
	localparam int unsigned CTL1_HALF = 6;
	localparam int unsigned CTL1_PCFG = 0;
	localparam int unsigned PIR_DONE  = 6;
	localparam logic [1:0] DIV_RC     = 2'h3;
	localparam logic [3:0] TRIG_MODE  = 4'hb;
	// ==========================================================
	// Timing: device oscillator period equals the clock period
	localparam int unsigned CLK_NS    = 10;
	localparam int unsigned TOSC_NS   = 10;
	localparam int unsigned TCY_TOSC  = 4;
	localparam int unsigned TCY_CYC   = (TCY_TOSC * TOSC_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned CONV_TADS = 9;
	localparam int unsigned HOLD_TADS = 2;
	// ==========================================================
	typedef enum logic [1:0] {ST_IDLE, ST_FIRST, ST_CONV, ST_HOLD} conv_phase_t;
	typedef struct packed {
		conv_phase_t phase;
		logic [6:0]  tad_cnt;
		logic [3:0]  bit_cnt;
		logic [2:0]  first_cnt;
		logic [7:0]  port_latch;
		logic [7:0]  port_dir;
		logic [7:0]  intc;
		logic [7:0]  pir;
		logic [7:0]  pie;
		logic [7:0]  ctl0;
		logic [7:0]  ctl1;
		logic [31:0] readdata;
		logic        waitreq;
		logic        timer_clear;
		logic        wake;
		logic        powered;
		logic        hold;
		logic [2:0]  rc_sync;
		logic [7:0]  pin_s1;
		logic [7:0]  pin_s2;
		logic [9:0]  code_s1;
		logic [9:0]  code_s2;
	} conv_state_t;
endpackage

// [logic/adc_conversion_control.sv]
// Converter control: register slave, conversion sequencer, port read masking
`timescale 1ns/1ps
module adc_conversion_control (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// Avalon-MM register slave
	input  wire logic [9:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [3:0]  byteenable,
	input  wire logic [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	// Port pins
	input  wire logic [7:0]  port_pin_in,
	output logic      [7:0]  port_pin_out,
	output logic      [7:0]  port_pin_oe,
	// Analog front end
	input  wire logic [9:0]  conv_code,
	input  wire logic        rc_clk_in,
	output logic      [2:0]  chan_sel,
	output logic             hold_disconnect,
	output logic             conv_powered,
	// Device and capture unit
	input  wire logic        sleep_mode,
	input  wire logic [3:0]  capture_mode_field,
	input  wire logic        special_trigger,
	output logic             timer_clear,
	output logic             wake
);
	conv_pkg::conv_state_t s_r, s_nxt;
	logic [15:0] res_r, res_nxt;

	// ==========================================================
	// Decoding helpers
	function automatic logic [4:0] analog_mask(input logic [3:0] pcfg);
		unique case (pcfg)
			4'h4, 4'h5:  analog_mask = 5'h0b;
			4'h6, 4'h7:  analog_mask = 5'h00;
			4'hd, 4'hf:  analog_mask = 5'h0f;
			4'he:        analog_mask = 5'h01;
			default:     analog_mask = 5'h1f;
		endcase
	endfunction

	function automatic logic [6:0] tad_cycles(input logic halve, input logic [1:0] div);
		tad_cycles = 7'(2 << (2 * div + {1'b0, halve}));
	endfunction

	// ==========================================================
	// Next state
	logic        rc_sel;
	logic        tad_tick;
	logic        wr_ok;
	logic        busy;
	logic        start;
	logic        abort;
	logic        done;
	logic [7:0]  sel;
	logic [7:0]  rd_val;
	logic [7:0]  wd;

	always_comb begin
		s_nxt = s_r;
		res_nxt = res_r;
		wd = writedata[7:0];
		sel = address[9:2];
		s_nxt.timer_clear = 1'b0;
		s_nxt.wake = 1'b0;
		s_nxt.waitreq = 1'b1;
		// Pin, code and RC clock synchronisers
		s_nxt.pin_s1 = port_pin_in;
		s_nxt.pin_s2 = s_r.pin_s1;
		s_nxt.code_s1 = conv_code;
		s_nxt.code_s2 = s_r.code_s1;
		s_nxt.rc_sync = {s_r.rc_sync[1:0], rc_clk_in};
		// Conversion bit period tick
		rc_sel = s_r.ctl0[conv_pkg::CTL0_DIV +: 2] == conv_pkg::DIV_RC;
		if (rc_sel) begin
			tad_tick = s_r.rc_sync[1] & ~s_r.rc_sync[2];
			s_nxt.tad_cnt = '0;
		end else begin
			tad_tick = s_r.tad_cnt == tad_cycles(s_r.ctl1[conv_pkg::CTL1_HALF],
				s_r.ctl0[conv_pkg::CTL0_DIV +: 2]) - 7'h1;
			s_nxt.tad_cnt = tad_tick ? 7'h0 : s_r.tad_cnt + 7'h1;
		end
		busy = s_r.phase == conv_pkg::ST_FIRST || s_r.phase == conv_pkg::ST_CONV;
		start = 1'b0;
		abort = 1'b0;
		done = 1'b0;
		// Read data is fetched in the first cycle of the request
		unique case (sel)
			conv_pkg::IDX_PORT: rd_val = s_r.pin_s2 & ~{3'h0,
				analog_mask(s_r.ctl1[conv_pkg::CTL1_PCFG +: 4])};
			conv_pkg::IDX_INTC: rd_val = s_r.intc;
			conv_pkg::IDX_PIR:  rd_val = s_r.pir;
			conv_pkg::IDX_RESH: rd_val = res_r[15:8];
			conv_pkg::IDX_CTL0: rd_val = s_r.ctl0;
			conv_pkg::IDX_DIR:  rd_val = s_r.port_dir;
			conv_pkg::IDX_PIE:  rd_val = s_r.pie;
			conv_pkg::IDX_RESL: rd_val = res_r[7:0];
			conv_pkg::IDX_CTL1: rd_val = s_r.ctl1;
			default:            rd_val = 8'h00;
		endcase
		if ((read || write) && s_r.waitreq) begin
			s_nxt.waitreq = 1'b0;
			s_nxt.readdata = {24'h0, address[1:0] == 2'h0 ? rd_val : 8'h00};
		end
		// Register writes take effect on the answering edge
		wr_ok = write && !s_r.waitreq && address[1:0] == 2'h0 && byteenable[0];
		if (wr_ok) begin
			unique case (sel)
				conv_pkg::IDX_PORT: s_nxt.port_latch = wd;
				conv_pkg::IDX_INTC: s_nxt.intc = wd;
				conv_pkg::IDX_PIR:  s_nxt.pir = wd & conv_pkg::MASK_PIRE;
				conv_pkg::IDX_RESH: res_nxt[15:8] = wd;
				conv_pkg::IDX_DIR:  s_nxt.port_dir = wd;
				conv_pkg::IDX_PIE:  s_nxt.pie = wd & conv_pkg::MASK_PIRE;
				conv_pkg::IDX_RESL: res_nxt[7:0] = wd;
				conv_pkg::IDX_CTL1: s_nxt.ctl1 = wd & conv_pkg::MASK_CTL1;
				conv_pkg::IDX_CTL0: begin
					s_nxt.ctl0 = wd & conv_pkg::MASK_CTL0;
					if (busy && !wd[conv_pkg::CTL0_GO]) begin
						abort = 1'b1;
					end else if (busy && !wd[conv_pkg::CTL0_ON]) begin
						abort = 1'b1;
						s_nxt.ctl0[conv_pkg::CTL0_GO] = 1'b0;
					end else if (s_r.phase == conv_pkg::ST_IDLE && wd[conv_pkg::CTL0_GO]
						&& wd[conv_pkg::CTL0_ON]) begin
						start = 1'b1;
					end else if (!busy) begin
						s_nxt.ctl0[conv_pkg::CTL0_GO] = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		// Special event trigger always clears the timer
		if (special_trigger) begin
			s_nxt.timer_clear = 1'b1;
			if (capture_mode_field == conv_pkg::TRIG_MODE && s_r.ctl0[conv_pkg::CTL0_ON]
				&& s_r.phase == conv_pkg::ST_IDLE && !abort) begin
				start = 1'b1;
				s_nxt.ctl0[conv_pkg::CTL0_GO] = 1'b1;
			end
		end
		// Sequencer
		unique case (s_r.phase)
			conv_pkg::ST_IDLE: begin
				if (start) begin
					s_nxt.phase = conv_pkg::ST_FIRST;
					s_nxt.first_cnt = '0;
					s_nxt.tad_cnt = '0;
				end
			end
			conv_pkg::ST_FIRST: begin
				if (s_r.first_cnt != 3'(conv_pkg::TCY_CYC - 1)) begin
					s_nxt.first_cnt = s_r.first_cnt + 3'h1;
				end else if (tad_tick) begin
					s_nxt.phase = conv_pkg::ST_CONV;
					s_nxt.bit_cnt = '0;
				end
			end
			conv_pkg::ST_CONV: begin
				if (tad_tick) begin
					s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
					if (s_r.bit_cnt == 4'(conv_pkg::CONV_TADS - 2)) begin
						done = 1'b1;
					end
				end
			end
			conv_pkg::ST_HOLD: begin
				if (tad_tick) begin
					s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
					if (s_r.bit_cnt == 4'(conv_pkg::HOLD_TADS - 1)) begin
						s_nxt.phase = conv_pkg::ST_IDLE;
					end
				end
			end
		endcase
		// Sleep without the RC clock powers the converter down
		if (sleep_mode && !rc_sel && busy) begin
			abort = 1'b1;
			done = 1'b0;
			s_nxt.ctl0[conv_pkg::CTL0_GO] = 1'b0;
			s_nxt.phase = conv_pkg::ST_IDLE;
		end else if (abort) begin
			done = 1'b0;
			s_nxt.phase = conv_pkg::ST_HOLD;
			// Restart the period so the wait spans two whole periods
			s_nxt.tad_cnt = '0;
			s_nxt.bit_cnt = '0;
		end
		if (done) begin
			// Code input is the selected pin level, whatever its direction
			res_nxt = s_r.ctl1[conv_pkg::CTL1_FMT] ? {6'h00, s_r.code_s2}
				: {s_r.code_s2, 6'h00};
			s_nxt.ctl0[conv_pkg::CTL0_GO] = 1'b0;
			s_nxt.pir[conv_pkg::PIR_DONE] = 1'b1;
			s_nxt.wake = sleep_mode && s_r.pie[conv_pkg::PIR_DONE];
			s_nxt.phase = conv_pkg::ST_HOLD;
			s_nxt.bit_cnt = '0;
		end
		s_nxt.powered = s_nxt.ctl0[conv_pkg::CTL0_ON] && !(sleep_mode && !rc_sel);
		s_nxt.hold = s_nxt.phase != conv_pkg::ST_IDLE;
	end

	// ==========================================================
	// State register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '{phase: conv_pkg::ST_IDLE, port_dir: conv_pkg::RST_DIR,
				intc: conv_pkg::RST_ZERO, pir: conv_pkg::RST_ZERO,
				pie: conv_pkg::RST_ZERO, ctl0: conv_pkg::RST_ZERO,
				ctl1: conv_pkg::RST_ZERO, waitreq: 1'b1, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// Result pair has no reset so it keeps its value across resets
	always_ff @(posedge ref_clk) begin
		res_r <= res_nxt;
	end

	// ==========================================================
	// Outputs
	assign readdata = s_r.readdata;
	assign waitrequest = s_r.waitreq;
	assign port_pin_out = s_r.port_latch;
	assign port_pin_oe = ~s_r.port_dir;
	assign chan_sel = s_r.ctl0[conv_pkg::CTL0_CHS +: 3];
	assign hold_disconnect = s_r.hold;
	assign conv_powered = s_r.powered;
	assign timer_clear = s_r.timer_clear;
	assign wake = s_r.wake;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	logic ctl0_wr;
	assign ctl0_wr = wr_ok && sel == conv_pkg::IDX_CTL0;

	property p_port_low;
		read && !waitrequest && sel == conv_pkg::IDX_PORT && address[1:0] == 2'h0
			&& s_r.ctl1[3:0] == 4'h0 |-> readdata[4:0] == 5'h00;
	endproperty
	a_port_low: assert property (p_port_low) else $error("analog pin read high");

	property p_abort;
		ctl0_wr && busy && !writedata[conv_pkg::CTL0_GO] && !sleep_mode
			|=> s_r.phase == conv_pkg::ST_HOLD && $stable(res_r);
	endproperty
	a_abort: assert property (p_abort) else $error("abort not taken");

	property p_hold_end;
		s_r.phase == conv_pkg::ST_HOLD && tad_tick && s_r.bit_cnt == 4'h1
			|=> s_r.phase == conv_pkg::ST_IDLE && !hold_disconnect;
	endproperty
	a_hold_end: assert property (p_hold_end) else $error("hold not two periods");

	// Checked on the way into the conversion, so a sleep abort does not trip it
	property p_first_min;
		s_r.phase == conv_pkg::ST_FIRST ##1 s_r.phase == conv_pkg::ST_CONV
			|-> $past(s_r.phase, 2) == conv_pkg::ST_FIRST
			&& $past(s_r.phase, 3) == conv_pkg::ST_FIRST
			&& $past(s_r.phase, 4) == conv_pkg::ST_FIRST;
	endproperty
	a_first_min: assert property (p_first_min) else $error("first segment short");

	property p_done;
		s_r.phase == conv_pkg::ST_CONV && tad_tick && s_r.bit_cnt == 4'h7 && !abort
			|=> !s_r.ctl0[conv_pkg::CTL0_GO] && s_r.pir[conv_pkg::PIR_DONE]
			&& s_r.phase == conv_pkg::ST_HOLD;
	endproperty
	a_done: assert property (p_done) else $error("completion not flagged");

	property p_justify;
		done && s_r.ctl1[conv_pkg::CTL1_FMT] |=> res_r[15:10] == 6'h00
			&& res_r[9:0] == $past(s_r.code_s2);
	endproperty
	a_justify: assert property (p_justify) else $error("right justify wrong");

	property p_trig_clear;
		special_trigger |=> timer_clear;
	endproperty
	a_trig_clear: assert property (p_trig_clear) else $error("timer not cleared");

	property p_trig_start;
		special_trigger && capture_mode_field == conv_pkg::TRIG_MODE
			&& s_r.ctl0[conv_pkg::CTL0_ON] && s_r.phase == conv_pkg::ST_IDLE && !wr_ok
			|=> s_r.ctl0[conv_pkg::CTL0_GO] && s_r.phase == conv_pkg::ST_FIRST;
	endproperty
	a_trig_start: assert property (p_trig_start) else $error("trigger start lost");

	property p_trig_ignored;
		special_trigger && !s_r.ctl0[conv_pkg::CTL0_ON] && s_r.phase == conv_pkg::ST_IDLE
			|=> s_r.phase == conv_pkg::ST_IDLE;
	endproperty
	a_trig_ignored: assert property (p_trig_ignored) else $error("trigger not ignored");

	property p_sleep_abort;
		sleep_mode && !rc_sel && busy |=> s_r.phase == conv_pkg::ST_IDLE && !conv_powered
			&& s_r.ctl0[conv_pkg::CTL0_ON] == $past(s_nxt.ctl0[conv_pkg::CTL0_ON]);
	endproperty
	a_sleep_abort: assert property (p_sleep_abort) else $error("sleep abort wrong");

	property p_go_busy;
		busy |-> s_r.ctl0[conv_pkg::CTL0_GO];
	endproperty
	a_go_busy: assert property (p_go_busy) else $error("go low while converting");

	c_done: cover property (done);
	c_abort: cover property (ctl0_wr && busy && !writedata[conv_pkg::CTL0_GO]);
	c_trig: cover property (special_trigger && s_r.phase == conv_pkg::ST_IDLE
		&& capture_mode_field == conv_pkg::TRIG_MODE && s_r.ctl0[conv_pkg::CTL0_ON]);
	c_sleep_rc: cover property (done && sleep_mode && rc_sel);
endmodule // adc_conversion_control

// [test/analog_side_model.sv]
// Analog front end and RC oscillator seen from the converter
`timescale 1ns/1ps
module analog_side_model (
	// Converter side
	input  wire logic [2:0] chan_sel,
	input  wire logic [7:0] port_pin_out,
	input  wire logic [7:0] port_pin_oe,
	// Analog side
	output logic      [9:0] conv_code,
	output logic            rc_clk_in
);
	// ==========================================================
	// Code of the selected pin
	always_comb begin
		if (port_pin_oe[chan_sel]) begin
			conv_code = port_pin_out[chan_sel] ? 10'h3ff : 10'h000;
		end else begin
			conv_code = {chan_sel, 7'h15};
		end
	end
	// ==========================================================
	// Free running RC source, 400 ns period
	initial rc_clk_in = 1'h0;
	always #200 rc_clk_in = ~rc_clk_in;
endmodule // analog_side_model

// [test/adc_conversion_control_bench.sv]
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module adc_conversion_control_bench;
	logic        ref_clk = 1'h0;
	logic        rst_n = 1'h0;
	logic [9:0]  address = 10'h000;
	logic        read = 1'h0;
	logic        write = 1'h0;
	logic [31:0] writedata = 32'h0000_0000;
	logic [31:0] readdata;
	logic        waitrequest;
	logic [7:0]  pin_ext = 8'hff;
	logic [7:0]  port_pin_in;
	logic [7:0]  port_pin_out;
	logic [7:0]  port_pin_oe;
	logic [9:0]  conv_code;
	logic        rc_clk_in;
	logic [2:0]  chan_sel;
	logic        hold_disconnect;
	logic        conv_powered;
	logic        timer_clear;
	logic        wake;
	logic        sleep_mode = 1'h0;
	logic [3:0]  capture_mode_field = 4'h0;
	logic        special_trigger = 1'h0;
	logic [3:0]  pcfg = 4'h0;
	logic [7:0]  v;
	int          n_mismatch = 0;
	int          compares = 0;
	int          hd_cnt = 0;
	int          tc_cnt = 0;
	int          wk_cnt = 0;

	always #5 ref_clk = ~ref_clk;
	// Wire level: driven bits show the latch, the rest the outside level
	assign port_pin_in = (port_pin_oe & port_pin_out) | (~port_pin_oe & pin_ext);
	always @(posedge ref_clk) begin
		if (hold_disconnect === 1'h1) hd_cnt++;
		if (timer_clear === 1'h1) tc_cnt++;
		if (wake === 1'h1) wk_cnt++;
	end

	adc_conversion_control u_adc_conversion_control (
		.ref_clk(ref_clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
		.byteenable(4'hf), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .port_pin_in(port_pin_in), .port_pin_out(port_pin_out),
		.port_pin_oe(port_pin_oe), .conv_code(conv_code), .rc_clk_in(rc_clk_in),
		.chan_sel(chan_sel), .hold_disconnect(hold_disconnect), .conv_powered(conv_powered),
		.sleep_mode(sleep_mode), .capture_mode_field(capture_mode_field),
		.special_trigger(special_trigger), .timer_clear(timer_clear), .wake(wake));
	analog_side_model u_analog_side_model (
		.chan_sel(chan_sel), .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe),
		.conv_code(conv_code), .rc_clk_in(rc_clk_in));

	// ==========================================================
	// Bus and check tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		address <= {idx, 2'h0};
		writedata <= {24'h00_0000, d};
		write <= 1'h1;
		do @(posedge ref_clk); while (waitrequest !== 1'h0);
		write <= 1'h0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [7:0] idx, output logic [7:0] d);
		address <= {idx, 2'h0};
		read <= 1'h1;
		do @(posedge ref_clk); while (waitrequest !== 1'h0);
		d = readdata[7:0];
		read <= 1'h0;
		@(posedge ref_clk);
	endtask
	task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] d;
		rd(idx, d);
		chk(d, exp);
	endtask
	task automatic idle_wait();
		do rd(conv_pkg::IDX_CTL0, v); while (v[2] === 1'h1);
		while (hold_disconnect !== 1'h0) @(posedge ref_clk);
	endtask
	task automatic trig();
		special_trigger <= 1'h1;
		@(posedge ref_clk);
		special_trigger <= 1'h0;
		repeat (2) @(posedge ref_clk);
	endtask
	// One conversion with result checks, timing checked unless the RC clock is chosen
	task automatic conv(input logic [1:0] dv, input logic hv, input logic fm,
			input logic [2:0] ch, input logic [9:0] code);
		int p;
		p = 2 << (2 * dv + hv);
		wr(conv_pkg::IDX_CTL1, {fm, hv, 2'h0, pcfg});
		wr(conv_pkg::IDX_CTL0, {dv, ch, 3'h1});
		wr(conv_pkg::IDX_PIR, 8'h00);
		hd_cnt = 0;
		wr(conv_pkg::IDX_CTL0, {dv, ch, 3'h5});
		rd(conv_pkg::IDX_CTL0, v);
		chk({7'h00, v[2]}, 8'h01);
		idle_wait();
		if (dv != 2'h3) chk({7'h00, hd_cnt >= 10 * p + 2 && hd_cnt <= 11 * p + 8}, 8'h01);
		rc(conv_pkg::IDX_PIR, 8'h40);
		rc(conv_pkg::IDX_RESH, fm ? {6'h00, code[9:8]} : code[9:2]);
		rc(conv_pkg::IDX_RESL, fm ? code[7:0] : {code[1:0], 6'h00});
	endtask
	task automatic summarize();
		if (n_mismatch == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		#400_000;
		n_mismatch++;
		summarize();
	end

	// ==========================================================
	// Test sequence
	initial begin
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'h1;
		@(posedge ref_clk);
		rc(conv_pkg::IDX_CTL0, 8'h00);
		rc(conv_pkg::IDX_CTL1, 8'h00);
		rc(conv_pkg::IDX_DIR, 8'hff);
		rc(conv_pkg::IDX_PIR, 8'h00);
		rc(conv_pkg::IDX_PIE, 8'h00);
		rc(8'h40, 8'h00);
		rc(conv_pkg::IDX_PORT, 8'he0);
		wr(conv_pkg::IDX_CTL1, 8'h0e);
		rc(conv_pkg::IDX_PORT, 8'hfe);
		wr(conv_pkg::IDX_CTL1, 8'h04);
		rc(conv_pkg::IDX_PORT, 8'hf4);
		wr(conv_pkg::IDX_RESH, 8'ha5);
		wr(conv_pkg::IDX_RESL, 8'h5a);
		rc(conv_pkg::IDX_RESH, 8'ha5);
		rc(conv_pkg::IDX_RESL, 8'h5a);
		// Every clock choice, both formats
		for (int i = 0; i < 8; i++) begin
			conv(i[2:1], i[0], i[0] ^ i[1], 3'(i % 5), {3'(i % 5), 7'h15});
		end
		// Output pin converts its driven level, digital input still converts
		wr(conv_pkg::IDX_DIR, 8'hfd);
		wr(conv_pkg::IDX_PORT, 8'h02);
		conv(2'h0, 1'h0, 1'h1, 3'h1, 10'h3ff);
		wr(conv_pkg::IDX_DIR, 8'hff);
		pcfg = 4'h6;
		conv(2'h0, 1'h0, 1'h1, 3'h2, {3'h2, 7'h15});
		pcfg = 4'h0;
		// Abort keeps the stored result
		wr(conv_pkg::IDX_RESH, 8'h12);
		wr(conv_pkg::IDX_RESL, 8'h34);
		wr(conv_pkg::IDX_CTL1, 8'h40);
		wr(conv_pkg::IDX_CTL0, 8'h81);
		wr(conv_pkg::IDX_CTL0, 8'h85);
		repeat (20) @(posedge ref_clk);
		wr(conv_pkg::IDX_CTL0, 8'h81);
		repeat (60) @(posedge ref_clk);
		chk({7'h00, hold_disconnect}, 8'h01);
		repeat (80) @(posedge ref_clk);
		chk({7'h00, hold_disconnect}, 8'h00);
		rc(conv_pkg::IDX_CTL0, 8'h81);
		rc(conv_pkg::IDX_RESH, 8'h12);
		rc(conv_pkg::IDX_RESL, 8'h34);
		// Special event trigger, enabled then disabled
		capture_mode_field <= conv_pkg::TRIG_MODE;
		wr(conv_pkg::IDX_CTL0, 8'h01);
		trig();
		rc(conv_pkg::IDX_CTL0, 8'h05);
		chk(8'(tc_cnt), 8'h01);
		idle_wait();
		wr(conv_pkg::IDX_CTL0, 8'h00);
		trig();
		rc(conv_pkg::IDX_CTL0, 8'h00);
		chk(8'(tc_cnt), 8'h02);
		// Sleep with the RC clock completes and wakes
		wr(conv_pkg::IDX_PIE, 8'h40);
		wr(conv_pkg::IDX_CTL0, 8'hc1);
		wr(conv_pkg::IDX_CTL0, 8'hc5);
		sleep_mode <= 1'h1;
		chk({7'h00, conv_powered}, 8'h01);
		idle_wait();
		chk(8'(wk_cnt), 8'h01);
		rc(conv_pkg::IDX_CTL0, 8'hc1);
		sleep_mode <= 1'h0;
		// Sleep with a divided clock aborts
		wr(conv_pkg::IDX_CTL0, 8'h81);
		wr(conv_pkg::IDX_CTL0, 8'h85);
		sleep_mode <= 1'h1;
		repeat (4) @(posedge ref_clk);
		rc(conv_pkg::IDX_CTL0, 8'h81);
		chk({7'h00, conv_powered}, 8'h00);
		sleep_mode <= 1'h0;
		// Reset in mid conversion
		wr(conv_pkg::IDX_RESH, 8'h77);
		wr(conv_pkg::IDX_CTL0, 8'h85);
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'h0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'h1;
		@(posedge ref_clk);
		chk({7'h00, hold_disconnect}, 8'h00);
		rc(conv_pkg::IDX_CTL0, 8'h00);
		rc(conv_pkg::IDX_RESH, 8'h77);
		summarize();
	end
endmodule // adc_conversion_control_bench
